/* File: rtl/mie_core.sv */
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
// Notes on behaviour
// - Call pushes next address, jumps, two cycles
// - Byte clear writes zero, flags untouched
// - Bit clear zeroes one selected bit only
// - Watchdog clear resets counter, timeout, power-down
// - Pre-clears act only when alternated
// - Complement inverts byte, updates zero flag
// - Decimal adjust adds six to each nibble above nine or with its carry set
// - Decimal adjust changes only carry flag
// - Decrement subtracts one, updates zero flag
// - Increment adds one, updates zero flag
// - Halt stops clock, keeps data, clears watchdog
// - Halt sets power-down, clears timeout
// - Jump loads target, two cycles, no flags
// - Moves copy data, no flag change
// - Idle only advances program counter
// - OR updates only zero flag
// - Return pops stack into counter
// - Return with value also loads working register
// - Interrupt return pops and sets global enable when none is pending
// - Pending interrupt served before resuming program
// - Pre-clear pair must be back to back
module mie_core
	import mie_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Instruction issue
	input  wire logic                  instr_valid,
	input  wire mie_op_t               instr_op,
	input  wire logic [`MIE_MEM_AW-1:0] instr_mem_addr,
	input  wire logic [2:0]            instr_bit,
	input  wire logic [7:0]            instr_imm,
	input  wire mie_pc_t               instr_target,
	output logic                       instr_ready,
	// Sequencer view
	output mie_pc_t                    pc_out,
	output logic                       clk_run,
	// Interrupt and wake
	input  wire logic                  irq_pending,
	input  wire logic                  wake_req,
	output logic                       irq_ack,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	// Watchdog
	output logic [7:0]                 wdog_count,
	output logic                       wdog_overflow
);

	mie_core_t st_ff;
	mie_core_t nxt_st;
	logic      accept;
	logic      is_pre;
	logic      is_pop;
	logic      stk_push;
	logic      stk_pop;
	mie_pc_t   stk_top;
	mie_pc_t   pc_inc;
	logic      wd_fire;
	logic      wd_ovf;
	logic      wd_clear_req;
	logic      wd_pre1_req;
	logic      wd_pre2_req;
	logic      wd_other_req;
	logic      wd_halt_req;
	mie_pc_t   stk_wdata;
	logic [7:0] rd_val;

	assign accept      = instr_valid && (st_ff.seq == seq_run);
	assign instr_ready = (st_ff.seq == seq_run);
	assign pc_out      = st_ff.pc;
	assign clk_run     = (st_ff.seq != seq_halt);
	assign irq_ack     = st_ff.irq_ack;
	assign reg_rdata   = st_ff.rdata;
	assign wdog_overflow = wd_ovf;
	assign pc_inc      = st_ff.pc + `MIE_PC_STEP;
	assign is_pre      = (instr_op == op_wdog_pre1) || (instr_op == op_wdog_pre2);
	assign is_pop      = (instr_op == op_sub_exit) || (instr_op == op_sub_exit_val)
		|| (instr_op == op_int_exit);
	assign stk_push    = accept && ((instr_op == op_call)
		|| ((instr_op == op_int_exit) && irq_pending));
	assign stk_pop     = accept && is_pop;
	// Return-to-vector re-pushes the popped address so the stack depth is kept
	assign stk_wdata    = (instr_op == op_call) ? pc_inc : stk_top;
	assign wd_clear_req = accept && (instr_op == op_wdog_clear);
	assign wd_pre1_req  = accept && (instr_op == op_wdog_pre1);
	assign wd_pre2_req  = accept && (instr_op == op_wdog_pre2);
	assign wd_other_req = accept && !is_pre;
	assign wd_halt_req  = accept && (instr_op == op_halt);

	mie_stack u_stack (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (stk_wdata),
		.top       (stk_top)
	);

	mie_wdog u_wdog (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.wd_clear      (wd_clear_req),
		.wd_pre_first  (wd_pre1_req),
		.wd_pre_second (wd_pre2_req),
		.wd_other_step (wd_other_req),
		.wd_halt_clear (wd_halt_req),
		.wd_fire       (wd_fire),
		.wd_count      (wdog_count),
		.wd_overflow   (wd_ovf)
	);

	always_comb begin
		logic [7:0] cur;
		logic [7:0] res;
		logic       wr_mem;
		logic       wr_wreg;
		logic       upd_z;
		logic       lo_adj;
		logic       hi_adj;
		logic [8:0] bcd_sum;
		cur     = st_ff.mem[instr_mem_addr];
		res     = 8'h00;
		wr_mem  = 1'b0;
		wr_wreg = 1'b0;
		upd_z   = 1'b0;
		lo_adj  = (st_ff.wreg[3:0] > `MIE_BCD_LIMIT) || st_ff.half_carry;
		hi_adj  = (st_ff.wreg[7:4] > `MIE_BCD_LIMIT) || st_ff.carry;
		bcd_sum = {1'b0, st_ff.wreg}
			+ {1'b0, (hi_adj ? `MIE_BCD_STEP : 4'h0), (lo_adj ? `MIE_BCD_STEP : 4'h0)};

		nxt_st = st_ff;
		nxt_st.rdata = 8'h00;
		nxt_st.irq_ack = 1'b0;

		// Software writes first, so an instruction in the same cycle overrides them
		if (reg_wr) begin
			if (reg_addr <= `MIE_ADDR_MEM_LAST) begin
				nxt_st.mem[reg_addr[`MIE_MEM_AW-1:0]] = reg_wdata;
			end else if (reg_addr == `MIE_ADDR_WREG) begin
				nxt_st.wreg = reg_wdata;
			end else if (reg_addr == `MIE_ADDR_STATUS) begin
				nxt_st.carry = reg_wdata[`MIE_ST_CARRY];
				nxt_st.half_carry = reg_wdata[`MIE_ST_HALF_CARRY];
				nxt_st.zero = reg_wdata[`MIE_ST_ZERO];
				nxt_st.gie = reg_wdata[`MIE_ST_GIE];
			end
		end

		// Data path of the byte operations
		unique case (instr_op)
			op_zero_fill: begin
				res = 8'h00;
				wr_mem = 1'b1;
			end
			op_zero_bit: begin
				res = cur & ~(8'h01 << instr_bit);
				wr_mem = 1'b1;
			end
			op_one_fill: begin
				res = 8'hFF;
				wr_mem = 1'b1;
			end
			op_one_bit: begin
				res = cur | (8'h01 << instr_bit);
				wr_mem = 1'b1;
			end
			op_compl, op_compl_w: begin
				res = ~cur;
				wr_mem = (instr_op == op_compl);
				wr_wreg = (instr_op == op_compl_w);
				upd_z = 1'b1;
			end
			op_bcd_adj: begin
				res = bcd_sum[7:0];
				wr_mem = 1'b1;
			end
			op_minus1, op_minus1_w: begin
				res = cur - 8'h01;
				wr_mem = (instr_op == op_minus1);
				wr_wreg = (instr_op == op_minus1_w);
				upd_z = 1'b1;
			end
			op_plus1, op_plus1_w: begin
				res = cur + 8'h01;
				wr_mem = (instr_op == op_plus1);
				wr_wreg = (instr_op == op_plus1_w);
				upd_z = 1'b1;
			end
			op_copy_mw: begin
				res = cur;
				wr_wreg = 1'b1;
			end
			op_copy_wm: begin
				res = st_ff.wreg;
				wr_mem = 1'b1;
			end
			op_copy_iw, op_sub_exit_val: begin
				res = instr_imm;
				wr_wreg = 1'b1;
			end
			op_or_mw, op_or_tomem: begin
				res = st_ff.wreg | cur;
				wr_mem = (instr_op == op_or_tomem);
				wr_wreg = (instr_op == op_or_mw);
				upd_z = 1'b1;
			end
			op_or_iw: begin
				res = st_ff.wreg | instr_imm;
				wr_wreg = 1'b1;
				upd_z = 1'b1;
			end
			op_rotl, op_rotl_w: begin
				res = {cur[6:0], cur[7]};
				wr_mem = (instr_op == op_rotl);
				wr_wreg = (instr_op == op_rotl_w);
			end
			default: begin
				res = 8'h00;
			end
		endcase

		unique case (st_ff.seq)
			seq_run: begin
				if (accept) begin
					nxt_st.pc = pc_inc;
					if (wr_mem) begin
						nxt_st.mem[instr_mem_addr] = res;
					end
					if (wr_wreg) begin
						nxt_st.wreg = res;
					end
					if (upd_z) begin
						nxt_st.zero = (res == 8'h00);
					end
					if (instr_op == op_bcd_adj) begin
						// A carry already set stays set through the adjust
						nxt_st.carry = hi_adj || bcd_sum[8];
					end
					unique case (instr_op)
						op_call, op_jump: begin
							nxt_st.pc = instr_target;
							nxt_st.seq = seq_dummy;
						end
						op_sub_exit, op_sub_exit_val: begin
							nxt_st.pc = stk_top;
							nxt_st.seq = seq_dummy;
						end
						op_int_exit: begin
							nxt_st.pc = stk_top;
							nxt_st.gie = 1'b1;
							nxt_st.seq = seq_dummy;
							if (irq_pending) begin
								// Return address stays on the stack for the routine's own exit
								nxt_st.pc = `MIE_IRQ_VECTOR;
								nxt_st.gie = 1'b0;
								nxt_st.irq_ack = 1'b1;
							end
						end
						op_halt: begin
							nxt_st.seq = seq_halt;
							nxt_st.power_down = 1'b1;
							nxt_st.timeout = 1'b0;
						end
						default: begin
							nxt_st.seq = seq_run;
						end
					endcase
				end
			end
			seq_dummy: begin
				nxt_st.seq = seq_run;
			end
			seq_halt: begin
				// Watchdog keeps counting while halted so it can still wake the part
				if (wake_req || irq_pending || wd_ovf) begin
					nxt_st.seq = seq_run;
				end
			end
			default: begin
				// Unused state code falls back to run
				nxt_st.seq = seq_run;
			end
		endcase

		if (wd_fire) begin
			nxt_st.timeout = 1'b0;
			nxt_st.power_down = 1'b0;
		end
		// Overflow wins over any clear in the same cycle
		if (wd_ovf) begin
			nxt_st.timeout = 1'b1;
		end

		if (reg_rd) begin
			nxt_st.rdata = rd_val;
		end
	end

	// Read mux sits apart so the returned byte is the state before this cycle's instruction
	always_comb begin
		rd_val = 8'h00;
		if (reg_addr <= `MIE_ADDR_MEM_LAST) begin
			rd_val = st_ff.mem[reg_addr[`MIE_MEM_AW-1:0]];
		end else begin
			case (reg_addr)
				`MIE_ADDR_WREG: begin
					rd_val = st_ff.wreg;
				end
				`MIE_ADDR_STATUS: begin
					rd_val[`MIE_ST_CARRY] = st_ff.carry;
					rd_val[`MIE_ST_HALF_CARRY] = st_ff.half_carry;
					rd_val[`MIE_ST_ZERO] = st_ff.zero;
					rd_val[`MIE_ST_TIMEOUT] = st_ff.timeout;
					rd_val[`MIE_ST_POWER_DOWN] = st_ff.power_down;
					rd_val[`MIE_ST_GIE] = st_ff.gie;
				end
				`MIE_ADDR_PC_LO: begin
					rd_val = st_ff.pc[7:0];
				end
				`MIE_ADDR_PC_HI: begin
					rd_val = {5'h00, st_ff.pc[`MIE_PC_W-1:8]};
				end
				`MIE_ADDR_WDOG: begin
					rd_val = wdog_count;
				end
				default: begin
					rd_val = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.seq <= seq_run;
			st_ff.pc <= `MIE_PC_RST;
			st_ff.wreg <= `MIE_WREG_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/mie_regs.svh */
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

// Storage sizes
`define MIE_MEM_DEPTH       32
`define MIE_MEM_AW          5
`define MIE_PC_W            11
`define MIE_STACK_DEPTH     8

// Register port map
`define MIE_ADDR_MEM_LAST   8'h1F
`define MIE_ADDR_WREG       8'h20
`define MIE_ADDR_STATUS     8'h21
`define MIE_ADDR_PC_LO      8'h22
`define MIE_ADDR_PC_HI      8'h23
`define MIE_ADDR_WDOG       8'h24

// Status byte fields
`define MIE_ST_CARRY        0
`define MIE_ST_HALF_CARRY   1
`define MIE_ST_ZERO         2
`define MIE_ST_TIMEOUT      3
`define MIE_ST_POWER_DOWN   4
`define MIE_ST_GIE          5

// Reset values and fixed addresses
`define MIE_PC_RST          11'h000
`define MIE_PC_STEP         11'h001
`define MIE_IRQ_VECTOR      11'h004
`define MIE_WREG_RST        8'h00

// Watchdog timing: top values of the prescaler, in cycles, and of the counter, in prescaler periods
`define MIE_WDOG_PRESC_MAX  8'hFF
`define MIE_WDOG_CNT_MAX    8'hFF

// Decimal adjust
`define MIE_BCD_LIMIT       4'h9
`define MIE_BCD_STEP        4'h6

`endif

/* File: rtl/mie_pkg.sv */
`default_nettype none
`include "mie_regs.svh"
package mie_pkg;

	typedef enum logic [4:0] {
		op_idle, op_call, op_jump, op_sub_exit, op_sub_exit_val, op_int_exit,
		op_zero_fill, op_zero_bit, op_one_fill, op_one_bit,
		op_wdog_clear, op_wdog_pre1, op_wdog_pre2,
		op_compl, op_compl_w, op_bcd_adj, op_minus1, op_minus1_w, op_plus1, op_plus1_w,
		op_copy_mw, op_copy_wm, op_copy_iw, op_or_mw, op_or_iw, op_or_tomem,
		op_rotl, op_rotl_w, op_halt
	} mie_op_t;

	typedef enum logic [1:0] {seq_run, seq_dummy, seq_halt} mie_seq_t;

	typedef enum logic [1:0] {pre_none, pre_first, pre_second} mie_pre_t;

	typedef logic [`MIE_PC_W-1:0] mie_pc_t;
	typedef logic [$clog2(`MIE_STACK_DEPTH)-1:0] mie_sp_t;

	typedef struct packed {
		mie_seq_t                           seq;
		mie_pc_t                            pc;
		logic [`MIE_MEM_DEPTH-1:0][7:0]     mem;
		logic [7:0]                         wreg;
		logic                               carry;
		logic                               half_carry;
		logic                               zero;
		logic                               timeout;
		logic                               power_down;
		logic                               gie;
		logic [7:0]                         rdata;
		logic                               irq_ack;
	} mie_core_t;

	typedef struct packed {
		logic [`MIE_STACK_DEPTH-1:0][`MIE_PC_W-1:0] entry;
		mie_sp_t                                    sp;
	} mie_stack_t;

	typedef struct packed {
		logic [7:0] presc;
		logic [7:0] cnt;
		mie_pre_t   pre;
		logic       overflow;
	} mie_wdog_t;

endpackage
`default_nettype wire

/* File: rtl/mie_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module mie_stack
	import mie_pkg::*;
(
	// Clock and reset
	input  wire logic    sys_clk,
	input  wire logic    reset,
	// Push and pop
	input  wire logic    push,
	input  wire logic    pop,
	input  wire mie_pc_t push_data,
	output mie_pc_t      top
);

	mie_stack_t stk_ff;
	mie_stack_t nxt_stk;
	mie_sp_t    sp_dec;

	assign sp_dec = stk_ff.sp - mie_sp_t'(1);
	assign top    = stk_ff.entry[sp_dec];

	// Pointer wraps on overflow: the oldest return address is lost
	always_comb begin
		nxt_stk = stk_ff;
		if (push && pop) begin
			nxt_stk.entry[sp_dec] = push_data;
		end else if (push) begin
			nxt_stk.entry[stk_ff.sp] = push_data;
			nxt_stk.sp = stk_ff.sp + mie_sp_t'(1);
		end else if (pop) begin
			nxt_stk.sp = sp_dec;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stk_ff <= '0;
		end else begin
			stk_ff <= nxt_stk;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/mie_wdog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mie_wdog
	import mie_pkg::*;
(
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  reset,
	// Clear requests
	input  wire logic  wd_clear,
	input  wire logic  wd_pre_first,
	input  wire logic  wd_pre_second,
	input  wire logic  wd_other_step,
	input  wire logic  wd_halt_clear,
	// Results
	output logic       wd_fire,
	output logic [7:0] wd_count,
	output logic       wd_overflow
);

	mie_wdog_t wd_ff;
	mie_wdog_t nxt_wd;

	assign wd_count    = wd_ff.cnt;
	assign wd_overflow = wd_ff.overflow;

	always_comb begin
		nxt_wd = wd_ff;
		nxt_wd.overflow = 1'b0;
		wd_fire = wd_clear;
		if (wd_pre_first) begin
			if (wd_ff.pre == pre_second) begin
				wd_fire = 1'b1;
				nxt_wd.pre = pre_none;
			end else begin
				nxt_wd.pre = pre_first;
			end
		end else if (wd_pre_second) begin
			if (wd_ff.pre == pre_first) begin
				wd_fire = 1'b1;
				nxt_wd.pre = pre_none;
			end else begin
				nxt_wd.pre = pre_second;
			end
		end else if (wd_other_step) begin
			// Any other instruction breaks a pre-clear pair
			nxt_wd.pre = pre_none;
		end
		if (wd_fire || wd_halt_clear) begin
			nxt_wd.presc = 8'h00;
			nxt_wd.cnt = 8'h00;
		end else if (wd_ff.presc == `MIE_WDOG_PRESC_MAX) begin
			nxt_wd.presc = 8'h00;
			nxt_wd.cnt = wd_ff.cnt + 8'h01;
			if (wd_ff.cnt == `MIE_WDOG_CNT_MAX) begin
				nxt_wd.cnt = 8'h00;
				nxt_wd.overflow = 1'b1;
			end
		end else begin
			nxt_wd.presc = wd_ff.presc + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wd_ff <= '0;
		end else begin
			wd_ff <= nxt_wd;
		end
	end

endmodule
`default_nettype wire

/* File: verification/mie_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mie_core_checker
	import mie_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       reset,
	// Instruction issue
	input wire logic       instr_valid,
	input wire mie_op_t    instr_op,
	input wire mie_pc_t    instr_target,
	input wire logic       instr_ready,
	// Sequencer and interrupt
	input wire mie_pc_t    pc_out,
	input wire logic       clk_run,
	input wire logic       irq_pending,
	input wire logic       wake_req,
	input wire logic       irq_ack,
	// Watchdog
	input wire logic [7:0] wdog_count,
	input wire logic       wdog_overflow
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic take;
	assign take = instr_valid && instr_ready;
	// Two-cycle ops leave exactly one dead issue slot
	sequence s_gap;
		!instr_ready ##1 instr_ready;
	endsequence
	sequence s_halted;
		!clk_run && !instr_ready;
	endsequence
	a_call_load_gap: assert property (take && instr_op == op_call |=> pc_out == $past(instr_target) ##0 s_gap)
		else $error("call target or timing wrong");
	a_jump_load_gap: assert property (take && instr_op == op_jump |=> pc_out == $past(instr_target) ##0 s_gap)
		else $error("jump target or timing wrong");
	a_return_gap: assert property (take && (instr_op == op_sub_exit || instr_op == op_sub_exit_val) |=> s_gap)
		else $error("return did not take two cycles");
	a_idle_step: assert property (take && instr_op == op_idle |=> pc_out == mie_pc_t'($past(pc_out) + `MIE_PC_STEP))
		else $error("idle did not advance counter by one");
	a_halt_enter: assert property (take && instr_op == op_halt |=> s_halted and (wdog_count == 8'h00))
		else $error("halt did not stop and clear watchdog");
	a_halt_hold: assert property (s_halted and (!wake_req && !irq_pending && !wdog_overflow) |=> s_halted)
		else $error("left halt without a wake source");
	a_halt_wake: assert property (!clk_run && wake_req |=> instr_ready && clk_run)
		else $error("wake did not resume in one cycle");
	a_irq_vector: assert property (take && instr_op == op_int_exit && irq_pending |=> irq_ack && pc_out == `MIE_IRQ_VECTOR)
		else $error("pending interrupt not vectored");
	a_irq_quiet: assert property (take && instr_op == op_int_exit && !irq_pending |=> !irq_ack ##1 instr_ready)
		else $error("plain interrupt exit misbehaved");
	a_wdog_clear: assert property (take && instr_op == op_wdog_clear |=> wdog_count == 8'h00)
		else $error("watchdog clear left count running");
endmodule
bind mie_core mie_core_checker mie_core_checker_i (
	.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
	.instr_target(instr_target), .instr_ready(instr_ready), .pc_out(pc_out), .clk_run(clk_run),
	.irq_pending(irq_pending), .wake_req(wake_req), .irq_ack(irq_ack), .wdog_count(wdog_count),
	.wdog_overflow(wdog_overflow)
);
`default_nettype wire

/* File: verification/mie_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mie_core_tb
	import mie_pkg::*;
;
	typedef struct packed {
		mie_op_t    op;
		logic [4:0] a;
		logic [7:0] v;
		logic [7:0] loc;
		logic [7:0] val;
		logic [7:0] st;
	} mie_step_t;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        instr_valid = 1'b0;
	mie_op_t     instr_op = op_idle;
	logic [4:0]  instr_mem_addr = 5'h00;
	logic [2:0]  instr_bit = 3'h0;
	logic [7:0]  instr_imm = 8'h00;
	mie_pc_t     instr_target = 11'h000;
	logic        irq_pending = 1'b0;
	logic        wake_req = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        instr_ready;
	logic        clk_run;
	logic        irq_ack;
	logic        wdog_overflow;
	mie_pc_t     pc_out;
	logic [7:0]  reg_rdata;
	logic [7:0]  wdog_count;
	int          num_errors = 0;
	int          tests_run = 0;
	int          ow = 0;
	logic        ovf_seen = 1'b0;
	mie_step_t   tab [22];
	logic [31:0] bcd [5];

	mie_core mie_core_i (
		.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_mem_addr(instr_mem_addr), .instr_bit(instr_bit), .instr_imm(instr_imm),
		.instr_target(instr_target), .instr_ready(instr_ready), .pc_out(pc_out), .clk_run(clk_run),
		.irq_pending(irq_pending), .wake_req(wake_req), .irq_ack(irq_ack), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.wdog_count(wdog_count), .wdog_overflow(wdog_overflow)
	);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, e);
	endtask

	task automatic wait_ready;
		int w;
		w = 0;
		while (instr_ready !== 1'b1 && w < 20) begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		if (w == 20) begin
			chk("instr_ready", {7'h00, instr_ready}, 8'h01);
			end_of_test();
		end
	endtask

	// The low bits of v double as the bit index
	task automatic ex(input mie_op_t op, input logic [4:0] a, input logic [7:0] v, input mie_pc_t t);
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_mem_addr <= a;
		instr_bit <= v[2:0];
		instr_imm <= v;
		instr_target <= t;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		if (op != op_halt) begin
			wait_ready();
		end
	endtask

	task automatic wake;
		chk("clk_run", {7'h00, clk_run}, 8'h00);
		@(posedge sys_clk) wake_req <= 1'b1;
		@(posedge sys_clk) wake_req <= 1'b0;
		#1;
		wait_ready();
	endtask

	initial begin
		tab = '{
			'{op_copy_iw, 5'h00, 8'h5A, 8'h20, 8'h5A, 8'h07}, '{op_copy_wm, 5'h03, 8'h00, 8'h03, 8'h5A, 8'h07},
			'{op_copy_mw, 5'h04, 8'h00, 8'h20, 8'h3C, 8'h07}, '{op_zero_bit, 5'h08, 8'h05, 8'h08, 8'h85, 8'h07},
			'{op_zero_fill, 5'h08, 8'h00, 8'h08, 8'h00, 8'h07}, '{op_rotl, 5'h07, 8'h00, 8'h07, 8'h03, 8'h07},
			'{op_rotl_w, 5'h07, 8'h00, 8'h20, 8'h06, 8'h07}, '{op_idle, 5'h00, 8'h00, 8'h07, 8'h03, 8'h07},
			'{op_or_mw, 5'h03, 8'h00, 8'h20, 8'h5E, 8'h03}, '{op_or_tomem, 5'h04, 8'h00, 8'h04, 8'h7E, 8'h03},
			'{op_idle, 5'h00, 8'h00, 8'h20, 8'h5E, 8'h03}, '{op_copy_iw, 5'h00, 8'h00, 8'h20, 8'h00, 8'h03},
			'{op_or_iw, 5'h00, 8'h00, 8'h20, 8'h00, 8'h07}, '{op_compl_w, 5'h05, 8'h00, 8'h20, 8'h00, 8'h07},
			'{op_idle, 5'h00, 8'h00, 8'h05, 8'hFF, 8'h07}, '{op_compl, 5'h05, 8'h00, 8'h05, 8'h00, 8'h07},
			'{op_compl, 5'h05, 8'h00, 8'h05, 8'hFF, 8'h03}, '{op_plus1, 5'h06, 8'h00, 8'h06, 8'h00, 8'h07},
			'{op_minus1, 5'h06, 8'h00, 8'h06, 8'hFF, 8'h03}, '{op_plus1_w, 5'h06, 8'h00, 8'h20, 8'h00, 8'h07},
			'{op_minus1_w, 5'h06, 8'h00, 8'h20, 8'hFE, 8'h03}, '{op_idle, 5'h00, 8'h00, 8'h06, 8'hFF, 8'h03}
		};
		// Packed as working value, flags before, adjusted byte, flags after
		bcd = '{32'hA5000501, 32'h45024B02, 32'h23058305, 32'h12041204, 32'h3C01A201};
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h21, 8'h00, "status");
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00, "unmapped");
		wr(8'h21, 8'h07);
		wr(8'h04, 8'h3C);
		wr(8'h05, 8'hFF);
		wr(8'h06, 8'hFF);
		wr(8'h07, 8'h81);
		wr(8'h08, 8'hA5);
		for (int i = 0; i < 22; i++) begin
			ex(tab[i].op, tab[i].a, tab[i].v, 11'h000);
			rd(tab[i].loc, tab[i].val, "data");
			rd(8'h21, tab[i].st, "flags");
		end
		for (int i = 0; i < 5; i++) begin
			wr(8'h21, bcd[i][23:16]);
			ex(op_copy_iw, 5'h00, bcd[i][31:24], 11'h000);
			ex(op_bcd_adj, 5'h09, 8'h00, 11'h000);
			rd(8'h09, bcd[i][15:8], "bcd");
			rd(8'h21, bcd[i][7:0], "bcd_flags");
		end
		ex(op_jump, 5'h00, 8'h00, 11'h100);
		rd(8'h23, 8'h01, "pc_hi");
		rd(8'h21, 8'h01, "flags");
		ex(op_call, 5'h00, 8'h00, 11'h234);
		rd(8'h22, 8'h34, "pc_lo");
		ex(op_sub_exit, 5'h00, 8'h00, 11'h000);
		rd(8'h22, 8'h01, "pc_lo");
		ex(op_call, 5'h00, 8'h00, 11'h300);
		ex(op_sub_exit_val, 5'h00, 8'h77, 11'h000);
		rd(8'h22, 8'h02, "pc_lo");
		rd(8'h20, 8'h77, "wreg");
		ex(op_call, 5'h00, 8'h00, 11'h050);
		ex(op_int_exit, 5'h00, 8'h00, 11'h000);
		rd(8'h22, 8'h03, "pc_lo");
		rd(8'h21, 8'h21, "flags");
		ex(op_call, 5'h00, 8'h00, 11'h060);
		@(posedge sys_clk) irq_pending <= 1'b1;
		ex(op_int_exit, 5'h00, 8'h00, 11'h000);
		rd(8'h22, 8'h04, "pc_lo");
		rd(8'h23, 8'h00, "pc_hi");
		rd(8'h21, 8'h01, "flags");
		@(posedge sys_clk) irq_pending <= 1'b0;
		ex(op_int_exit, 5'h00, 8'h00, 11'h000);
		rd(8'h22, 8'h04, "pc_lo");
		rd(8'h23, 8'h01, "pc_hi");
		ex(op_halt, 5'h00, 8'h00, 11'h000);
		wake();
		rd(8'h21, 8'h31, "flags");
		rd(8'h05, 8'hFF, "mem");
		// Halt zeroed the watchdog, so about 600 cycles later it has counted exactly twice
		repeat (600) @(posedge sys_clk);
		ex(op_wdog_pre1, 5'h00, 8'h00, 11'h000);
		ex(op_wdog_pre1, 5'h00, 8'h00, 11'h000);
		rd(8'h24, 8'h02, "wdog");
		rd(8'h21, 8'h31, "flags");
		ex(op_wdog_pre2, 5'h00, 8'h00, 11'h000);
		rd(8'h24, 8'h00, "wdog");
		rd(8'h21, 8'h21, "flags");
		ex(op_halt, 5'h00, 8'h00, 11'h000);
		// Only the watchdog can end this halt: it must overflow, raise timeout and wake the part
		while (clk_run !== 1'b1 && ow < 70000) begin
			@(posedge sys_clk);
			#1;
			ovf_seen = ovf_seen | wdog_overflow;
			ow++;
		end
		chk("wdog_overflow", {7'h00, ovf_seen}, 8'h01);
		chk("clk_run", {7'h00, clk_run}, 8'h01);
		if (clk_run !== 1'b1) begin
			end_of_test();
		end
		rd(8'h21, 8'h39, "flags");
		ex(op_wdog_clear, 5'h00, 8'h00, 11'h000);
		rd(8'h24, 8'h00, "wdog");
		rd(8'h21, 8'h21, "flags");
		end_of_test();
	end
endmodule
`default_nettype wire
